// [rtl/keypad_matrix_pkg.sv]
// Package: register map, field layout, timing and bus carrier of the keypad matrix control
package keypad_matrix_pkg;

  // ----------------------------------------------------------------
  // Address window and register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] KPAD_BASE_HI      = 16'hd826;     // Address bits 31:16 that select the 64 KB window
  localparam logic [15:0] OFS_MATRIX_CTRL   = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions of matrix_scan_control
  // ----------------------------------------------------------------
  localparam int          BIT_ENABLE        = 0;
  localparam int          BIT_SCAN_NOW      = 2;
  localparam int          BIT_SCAN_ACTIVITY = 3;
  localparam int          COL_CNT_LSB       = 8;
  localparam int          ROW_CNT_LSB       = 12;
  localparam int          MAN_COL_LSB       = 16;
  localparam logic [31:0] CTRL_WRITE_MASK   = 32'h00ff_771f; // Reserved 31:24, 15, 11 stay zero
  localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Scan timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS     = 20;
  localparam int          COL_DWELL_NS      = 1000;        // Settle time per driven column
  localparam int          COL_DWELL_CYC_I   = (COL_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  COL_DWELL_CYC     = 8'(COL_DWELL_CYC_I);

  // ----------------------------------------------------------------
  // Peripheral bus request carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } bus_req_t;

  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b01,
    SCAN_RUN  = 2'b10
  } scan_state_t;

endpackage

// [rtl/keypad_matrix_control.sv]
// Keypad matrix control register with column drive and automatic scan sequencer
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1: Flag keypad select for any access inside 64 KB window; decode offset within it.
// RULE2: Manual mode with enable set drives columns from manual field bits 23:16.
// RULE3: Auto mode with enable set hands counted columns to the scan sequencer.
// RULE4: Columns beyond the column count always follow the manual field bits.
// RULE5: Active rows equal row count field 14:12 plus one; field resets zero.
// RULE6: Active columns equal column count field 10:8 plus one; field resets zero.
// RULE7: Row count n samples only row inputs 0 through n.
// RULE8: Column count n scans only column outputs 0 through n.
// RULE9: Reserved bits 31:24, 15, 11 read zero and ignore writes.
// RULE10: Activity bit 3 starts a scan on row activity; cleared, no activity scan.
// RULE11: Bit 2 starts a scan, self clears, wins over bit 3, restarts scanning.
module keypad_matrix_control (
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  input  wire keypad_matrix_pkg::bus_req_t bus_req,
  input  wire logic [7:0]                 row_in,
  output logic                            kpad_psel,
  output logic                            pready,
  output logic [31:0]                     prdata,
  output logic [7:0]                      col_out,
  output logic                            scan_busy,
  output logic                            key_found
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        in_window;
  logic        hit_ctrl;
  logic        wr_ctrl;
  logic [31:0] ctrl;

  // Window match and register decode
  assign in_window = bus_req.psel && (bus_req.paddr[31:16] == keypad_matrix_pkg::KPAD_BASE_HI);
  assign hit_ctrl  = bus_req.paddr[15:2] == keypad_matrix_pkg::OFS_MATRIX_CTRL[15:2]; // [RULE1]
  assign wr_ctrl   = in_window && bus_req.penable && bus_req.pwrite && hit_ctrl;

  // Select, ready and read data registered in the setup phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      kpad_psel <= 1'b0;
      pready    <= 1'b0;
      prdata    <= 32'h0000_0000;
    end else begin
      kpad_psel <= in_window;                                  // [RULE1]
      pready    <= in_window && !bus_req.penable;
      if (in_window && !bus_req.penable) begin
        prdata <= hit_ctrl ? (ctrl & keypad_matrix_pkg::CTRL_WRITE_MASK) : 32'h0000_0000; // [RULE9]
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic       en;
  logic       scan_now;
  logic       scan_act;
  logic       auto_mode;
  logic [2:0] col_cnt;
  logic [2:0] row_cnt;
  logic [7:0] man_col;
  logic       launch_now;
  logic       launch_act;
  keypad_matrix_pkg::scan_state_t state;

  assign en        = ctrl[keypad_matrix_pkg::BIT_ENABLE];
  assign scan_now  = ctrl[keypad_matrix_pkg::BIT_SCAN_NOW];
  assign scan_act  = ctrl[keypad_matrix_pkg::BIT_SCAN_ACTIVITY];
  // Immediate bit clears at launch, so a running scan keeps the counted columns
  assign auto_mode = scan_now || scan_act
                     || (state == keypad_matrix_pkg::SCAN_RUN); // [RULE3]
  assign col_cnt   = ctrl[keypad_matrix_pkg::COL_CNT_LSB +: 3]; // [RULE6]
  assign row_cnt   = ctrl[keypad_matrix_pkg::ROW_CNT_LSB +: 3]; // [RULE5]
  assign man_col   = ctrl[keypad_matrix_pkg::MAN_COL_LSB +: 8];

  // Software write wins over the self clear of the immediate bit
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl <= keypad_matrix_pkg::CTRL_RESET;                   // [RULE5] [RULE6]
    end else if (wr_ctrl) begin
      ctrl <= bus_req.pwdata & keypad_matrix_pkg::CTRL_WRITE_MASK; // [RULE9]
    end else if (launch_now) begin
      ctrl[keypad_matrix_pkg::BIT_SCAN_NOW] <= 1'b0;          // [RULE11]
    end
  end

  // ----------------------------------------------------------------
  // Row masking and scan launch
  // ----------------------------------------------------------------
  logic [7:0] row_mask;
  logic [7:0] col_mask;
  logic       row_activity;

  // Thermometer masks: count n enables lines 0..n
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      row_mask[i] = 3'(i) <= row_cnt;                          // [RULE7]
      col_mask[i] = 3'(i) <= col_cnt;                          // [RULE8]
    end
  end

  assign row_activity = |(row_in & row_mask);                  // [RULE7]
  assign launch_now   = en && scan_now;                        // [RULE11]
  assign launch_act   = en && scan_act && !scan_now && row_activity
                        && (state == keypad_matrix_pkg::SCAN_IDLE); // [RULE10]

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  logic [2:0] col_idx;
  logic [7:0] dwell;
  logic       found_acc;
  logic       col_last;
  logic       dwell_end;

  assign col_last  = col_idx == col_cnt;                       // [RULE8]
  assign dwell_end = dwell == keypad_matrix_pkg::COL_DWELL_CYC - 8'h01;

  // State, column walk and dwell count; immediate launch restarts at column 0
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state   <= keypad_matrix_pkg::SCAN_IDLE;
      col_idx <= 3'h0;
      dwell   <= 8'h00;
    end else if (!en) begin
      state   <= keypad_matrix_pkg::SCAN_IDLE;
      col_idx <= 3'h0;
      dwell   <= 8'h00;
    end else if (launch_now || launch_act) begin
      state   <= keypad_matrix_pkg::SCAN_RUN;                  // [RULE10] [RULE11]
      col_idx <= 3'h0;
      dwell   <= 8'h00;
    end else begin
      unique case (state)
        keypad_matrix_pkg::SCAN_IDLE: begin
          dwell <= 8'h00;
        end
        keypad_matrix_pkg::SCAN_RUN: begin
          if (!dwell_end) begin
            dwell <= dwell + 8'h01;
          end else begin
            dwell <= 8'h00;
            if (col_last) begin
              state   <= keypad_matrix_pkg::SCAN_IDLE;
              col_idx <= 3'h0;
            end else begin
              col_idx <= col_idx + 3'h1;
            end
          end
        end
      endcase
    end
  end

  // Key result; a restart discards the partial result
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      found_acc <= 1'b0;
      key_found <= 1'b0;
    end else if (launch_now || launch_act || !en) begin
      found_acc <= 1'b0;                                       // [RULE11]
    end else if (state == keypad_matrix_pkg::SCAN_RUN && dwell_end) begin
      if (col_last) begin
        key_found <= found_acc || row_activity;
        found_acc <= 1'b0;
      end else begin
        found_acc <= found_acc || row_activity;                // [RULE7]
      end
    end
  end

  // ----------------------------------------------------------------
  // Column drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      col_out   <= 8'h00;
      scan_busy <= 1'b0;
    end else begin
      scan_busy <= state == keypad_matrix_pkg::SCAN_RUN;
      for (int i = 0; i < 8; i++) begin
        if (en && auto_mode && col_mask[i]) begin
          col_out[i] <= (state == keypad_matrix_pkg::SCAN_RUN) && (col_idx == 3'(i)); // [RULE3]
        end else begin
          col_out[i] <= man_col[i];                            // [RULE2] [RULE4]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_sel_window;
    @(posedge clk_sys) disable iff (reset)
      in_window |=> kpad_psel;
  endproperty
  a_sel_window: assert property (p_sel_window) else $error("select missed window"); // [RULE1]

  property p_manual_drive;
    @(posedge clk_sys) disable iff (reset)
      (en && !auto_mode) |=> (col_out == $past(man_col));
  endproperty
  a_manual_drive: assert property (p_manual_drive) else $error("manual columns wrong"); // [RULE2]

  property p_auto_drive;
    @(posedge clk_sys) disable iff (reset)
      (en && auto_mode && state == keypad_matrix_pkg::SCAN_RUN)
        |=> ((col_out & $past(col_mask)) == (8'h01 << $past(col_idx)));
  endproperty
  a_auto_drive: assert property (p_auto_drive) else $error("scan column wrong"); // [RULE3]

  property p_gpo_drive;
    @(posedge clk_sys) disable iff (reset)
      1'b1 |=> ((col_out & ~$past(col_mask)) == ($past(man_col) & ~$past(col_mask)));
  endproperty
  a_gpo_drive: assert property (p_gpo_drive) else $error("unused column not manual"); // [RULE4]

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (reset)
      (prdata & ~keypad_matrix_pkg::CTRL_WRITE_MASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // [RULE9]

  property p_no_activity_scan;
    @(posedge clk_sys) disable iff (reset)
      (state == keypad_matrix_pkg::SCAN_IDLE && !scan_now && !scan_act)
        |=> (state == keypad_matrix_pkg::SCAN_IDLE);
  endproperty
  a_no_activity_scan: assert property (p_no_activity_scan) else $error("scan without cause"); // [RULE10]

  property p_activity_scan;
    @(posedge clk_sys) disable iff (reset)
      (en && scan_act && row_activity && state == keypad_matrix_pkg::SCAN_IDLE)
        |=> (state == keypad_matrix_pkg::SCAN_RUN) ##1 scan_busy;
  endproperty
  a_activity_scan: assert property (p_activity_scan) else $error("activity scan not started"); // [RULE10]

  property p_now_clears;
    @(posedge clk_sys) disable iff (reset)
      (launch_now && !wr_ctrl) |=> (!scan_now && state == keypad_matrix_pkg::SCAN_RUN
                                    && col_idx == 3'h0 && dwell == 8'h00);
  endproperty
  a_now_clears: assert property (p_now_clears) else $error("immediate scan mishandled"); // [RULE11]

  property p_scan_length;
    @(posedge clk_sys) disable iff (reset)
      (state == keypad_matrix_pkg::SCAN_RUN) |-> ##[0:400] (state == keypad_matrix_pkg::SCAN_IDLE);
  endproperty
  a_scan_length: assert property (p_scan_length) else $error("scan overran"); // [RULE8]

  c_write_ctrl: cover property (@(posedge clk_sys) disable iff (reset) wr_ctrl);
  c_now_scan:   cover property (@(posedge clk_sys) disable iff (reset) launch_now);
  c_act_scan:   cover property (@(posedge clk_sys) disable iff (reset) launch_act);
  c_found:      cover property (@(posedge clk_sys) disable iff (reset) $rose(key_found));

endmodule

`default_nettype wire

// [dv/keypad_switch_matrix.sv]
// Behavioural switch matrix: one key joins a column line to a row line
`timescale 1ns/1ps
`default_nettype none

module keypad_switch_matrix (
  input  wire logic [7:0] col_out,
  input  wire logic       key_on,
  input  wire logic [2:0] key_row,
  input  wire logic [2:0] key_col,
  output logic      [7:0] row_in
);
  // Rows sit on pull-downs; a closed key copies its column level
  always_comb begin
    row_in = 8'h00;
    if (key_on && col_out[key_col]) begin
      row_in[key_row] = 1'b1;
    end
  end
endmodule

`default_nettype wire

// [dv/tb_top.sv]
// Register, column drive and scan tests of the keypad matrix control
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                        clk_sys = 1'b0;
  logic                        reset = 1'b1;
  keypad_matrix_pkg::bus_req_t bus_req = '0;
  logic [7:0]                  row_in;
  logic [7:0]                  col_out;
  logic                        kpad_psel;
  logic                        pready;
  logic                        scan_busy;
  logic                        key_found;
  logic [31:0]                 prdata;
  logic                        key_on = 1'b0;
  logic [2:0]                  key_row = 3'h0;
  logic [2:0]                  key_col = 3'h0;
  logic [31:0]                 rd;
  int                          miscompares = 0;
  int                          n_tests = 0;
  int                          cnt;
  logic [31:0]                 tbl_ctrl [4] = '{32'h00f0_0105, 32'h00f0_0105,
                                                32'h00f0_0105, 32'h00f0_1105};
  logic [5:0]                  tbl_key [4] = '{6'o01, 6'o02, 6'o10, 6'o10};
  logic                        tbl_hit [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  // Free-running system clock
  always #10 clk_sys = ~clk_sys;

  keypad_matrix_control u_keypad_matrix_control (
    .clk_sys(clk_sys), .reset(reset), .bus_req(bus_req), .row_in(row_in),
    .kpad_psel(kpad_psel), .pready(pready), .prdata(prdata), .col_out(col_out),
    .scan_busy(scan_busy), .key_found(key_found));

  keypad_switch_matrix u_keypad_switch_matrix (
    .col_out(col_out), .key_on(key_on), .key_row(key_row), .key_col(key_col),
    .row_in(row_in));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One bus transfer: setup, access, release after the access edge
  task acc(input logic w, input logic [31:0] a, input logic [31:0] d, input logic hit);
    @(negedge clk_sys);
    bus_req.psel = 1'b1;
    bus_req.penable = 1'b0;
    bus_req.pwrite = w;
    bus_req.paddr = a;
    bus_req.pwdata = d;
    @(negedge clk_sys);
    bus_req.penable = 1'b1;
    chk({31'h0, kpad_psel}, {31'h0, hit});
    chk({31'h0, pready}, {31'h0, hit});
    @(negedge clk_sys);
    rd = prdata;
    bus_req.psel = 1'b0;
    bus_req.penable = 1'b0;
  endtask

  // Bounded wait for scan_busy to reach a level; cnt holds the cycles taken
  task wait_busy(input logic lvl);
    for (cnt = 0; cnt < 1000 && scan_busy !== lvl; cnt++) begin
      @(negedge clk_sys);
    end
    if (cnt == 1000) begin
      miscompares++;
      $display("ERROR %0t: scan wait ran out", $time);
      finish_test();
    end
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    acc(1'b0, 32'hd826_0000, 32'h0, 1'b1);
    chk(rd, 32'h0);
    acc(1'b1, 32'hd826_0000, 32'hffff_fffe, 1'b1);
    acc(1'b0, 32'hd826_0000, 32'h0, 1'b1);
    chk(rd, 32'h00ff_771e);
    acc(1'b1, 32'hd826_0004, 32'hffff_ffff, 1'b1);
    acc(1'b0, 32'hd826_0004, 32'h0, 1'b1);
    chk(rd, 32'h0);
    acc(1'b1, 32'hd827_0000, 32'h0, 1'b0);
    acc(1'b0, 32'hd826_0000, 32'h0, 1'b1);
    chk(rd, 32'h00ff_771e);
    $display("register tests done");
    acc(1'b1, 32'hd826_0000, 32'h00a5_0001, 1'b1);
    @(negedge clk_sys);
    chk({24'h0, col_out}, 32'h0000_00a5);
    $display("manual drive test done");
    // Immediate scans over key positions inside and outside the counts
    for (int i = 0; i < 4; i++) begin
      {key_row, key_col} = tbl_key[i];
      key_on = 1'b1;
      acc(1'b1, 32'hd826_0000, tbl_ctrl[i], 1'b1);
      wait_busy(1'b1);
      chk({24'h0, col_out}, 32'h0000_00f1);
      wait_busy(1'b0);
      chk(cnt, 2 * keypad_matrix_pkg::COL_DWELL_CYC_I);
      @(negedge clk_sys);
      chk({31'h0, key_found}, {31'h0, tbl_hit[i]});
      chk({24'h0, col_out}, 32'h0000_00f0);
      acc(1'b0, 32'hd826_0000, 32'h0, 1'b1);
      chk(rd, tbl_ctrl[i] & 32'hffff_fffb);
    end
    $display("immediate scan tests done");
    // A key on a spare output column makes row activity
    {key_row, key_col} = 6'o01;
    acc(1'b1, 32'hd826_0000, 32'h0002_0009, 1'b1);
    wait_busy(1'b1);
    chk({31'h0, scan_busy}, 32'h1);
    // Immediate bit mid scan restarts at column 0 and drops the partial result
    repeat (20) @(negedge clk_sys);
    key_on = 1'b0;
    acc(1'b1, 32'hd826_0000, 32'h0002_000d, 1'b1);
    wait_busy(1'b0);
    chk(cnt, keypad_matrix_pkg::COL_DWELL_CYC_I + 2);
    @(negedge clk_sys);
    chk({31'h0, key_found}, 32'h0);
    acc(1'b0, 32'hd826_0000, 32'h0, 1'b1);
    chk(rd, 32'h0002_0009);
    acc(1'b1, 32'hd826_0000, 32'h0002_0001, 1'b1);
    key_on = 1'b1;
    repeat (20) @(negedge clk_sys);
    chk({31'h0, scan_busy}, 32'h0);
    $display("activity scan tests done");
    finish_test();
  end
endmodule

`default_nettype wire
